// *** valve_actuator_drive.sv ***
// Valve actuator drive: PWM, time-proportional valve pulses, analog code.
// Assumes one AHB-Lite master, word accesses, 100 MHz CLK.
`timescale 1ns/100ps
module valve_actuator_drive
   import vad_pkg::*;
#(
   parameter int MS_CLKS = MS_CYCLES  // Clock cycles per millisecond
) (
   input wire logic CLK,              // System clock, 100 MHz
   input wire logic RST_N,            // Synchronous reset, active low
   input wire logic HSEL,             // Slave select
   input wire logic [31:0] HADDR,     // Byte address
   input wire logic [1:0] HTRANS,     // Transfer type
   input wire logic HWRITE,           // Write when high
   input wire logic [2:0] HSIZE,      // Transfer size, word only
   input wire logic [31:0] HWDATA,    // Write data
   input wire logic HREADY,           // Bus ready
   output logic [31:0] HRDATA,        // Read data
   output logic HREADYOUT,            // Slave ready
   output logic HRESP,                // Response, always OKAY
   output logic PWM_OUT,              // Proportional valve drive
   output logic VALVE1_OUT,           // First transistor output
   output logic VALVE2_OUT,           // Second transistor output
   output logic [15:0] AOUT_CODE,     // Analog code, uA or mV
   output logic AOUT_VOLT             // High when code is in mV
);
   // ==========================================================
   // Register file
   logic [5:0] ctrl_r, ctrl_nxt;
   logic signed [10:0] mv_r, mv_nxt;
   logic [15:0] fhi_r, fhi_nxt, flo_r, flo_nxt;
   logic [10:0] dmax_r, dmax_nxt;
   logic [13:0] tmin1_r, tmin1_nxt, tmin2_r, tmin2_nxt;
   logic [13:0] cycle_r, cycle_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic addr_ok;
   logic signed [15:0] wmv;
   drive_mode_t mode;
   logic pol1, pol2;

   assign addr_ok = HSEL && HTRANS[1] && HREADY;
   assign wmv = signed'(HWDATA[15:0]);
   assign mode = drive_mode_t'(ctrl_r[2:0]);
   assign pol1 = ctrl_r[CTRL_POL1_BIT];
   assign pol2 = ctrl_r[CTRL_POL2_BIT];

   logic [10:0] duty_cur;
   logic [15:0] freq_cur;
   logic clamped;
   logic pwm_r, pwm_nxt;
   logic act1, act2;
   logic [15:0] aout_r, aout_nxt;

   always_comb begin
      ctrl_nxt = ctrl_r;
      mv_nxt = mv_r;
      fhi_nxt = fhi_r;
      flo_nxt = flo_r;
      dmax_nxt = dmax_r;
      tmin1_nxt = tmin1_r;
      tmin2_nxt = tmin2_r;
      cycle_nxt = cycle_r;
      wr_pend_nxt = addr_ok && HWRITE;
      addr_nxt = addr_ok ? HADDR[7:0] : addr_r;
      if (wr_pend_r) begin
         case (addr_r)
            ADDR_CTRL: ctrl_nxt = HWDATA[5:0];
            ADDR_MV: begin
               if (wmv > 16'sd1000) begin
                  mv_nxt = 11'sd1000;
               end else if (wmv < -16'sd1000) begin
                  mv_nxt = -11'sd1000;
               end else begin
                  mv_nxt = wmv[10:0];
               end
            end
            ADDR_FREQ: begin
               fhi_nxt = HWDATA[15:0];
               flo_nxt = HWDATA[31:16];
            end
            ADDR_DMAX: begin
               dmax_nxt = (HWDATA[10:0] > PM_FULL) ? PM_FULL : HWDATA[10:0];
            end
            ADDR_TMIN1: tmin1_nxt = clamp_tmin(HWDATA);
            ADDR_TMIN2: tmin2_nxt = clamp_tmin(HWDATA);
            ADDR_CYCLE: begin
               cycle_nxt = (HWDATA[13:0] == 14'h0000) ? 14'h0001 : HWDATA[13:0];
            end
            default: ;
         endcase
      end
      // Reads see a write that lands in the same cycle
      rdata_nxt = rdata_r;
      if (addr_ok && !HWRITE) begin
         case (HADDR[7:0])
            ADDR_CTRL: rdata_nxt = {26'h0, ctrl_nxt};
            ADDR_MV: rdata_nxt = {{21{mv_nxt[10]}}, mv_nxt};
            ADDR_FREQ: rdata_nxt = {flo_nxt, fhi_nxt};
            ADDR_DMAX: rdata_nxt = {21'h0, dmax_nxt};
            ADDR_TMIN1: rdata_nxt = {18'h0, tmin1_nxt};
            ADDR_TMIN2: rdata_nxt = {18'h0, tmin2_nxt};
            ADDR_CYCLE: rdata_nxt = {18'h0, cycle_nxt};
            ADDR_STATUS: begin
               rdata_nxt = {16'h0, freq_cur};
               rdata_nxt[STAT_PWM_BIT] = pwm_r;
               rdata_nxt[STAT_ACT1_BIT] = act1;
               rdata_nxt[STAT_ACT2_BIT] = act2;
               rdata_nxt[STAT_CLAMP_BIT] = clamped;
            end
            ADDR_AOUT: rdata_nxt = {16'h0, aout_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_r <= CTRL_RESET;
         mv_r <= 11'sd0;
         fhi_r <= FHI_RESET;
         flo_r <= FLO_RESET;
         dmax_r <= DMAX_RESET;
         tmin1_r <= TMIN_RESET;
         tmin2_r <= TMIN_RESET;
         cycle_r <= CYCLE_RESET;
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         rdata_r <= 32'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mv_r <= mv_nxt;
         fhi_r <= fhi_nxt;
         flo_r <= flo_nxt;
         dmax_r <= dmax_nxt;
         tmin1_r <= tmin1_nxt;
         tmin2_r <= tmin2_nxt;
         cycle_r <= cycle_nxt;
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign HRDATA = rdata_r;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // ==========================================================
   // Proportional valve PWM with duty-dependent frequency
   logic [15:0] span;
   logic [39:0] fprod;
   logic [31:0] phase_r, phase_nxt;
   logic [31:0] thr_r, thr_nxt;
   logic [31:0] inc_r, inc_nxt;
   logic [32:0] psum;

   always_comb begin
      clamped = 1'b0;
      if (mode != MODE_PROP || mv_r <= 11'sd0) begin
         duty_cur = 11'h000;
      end else if (mv_r[10:0] > dmax_r) begin
         duty_cur = dmax_r;
         clamped = 1'b1;
      end else begin
         duty_cur = mv_r[10:0];
      end
      span = (fhi_r > flo_r) ? 16'(fhi_r - flo_r) : 16'h0000;
      if (duty_cur <= PM_PEAK) begin
         fprod = 40'(span) * 40'(duty_cur) * 40'(RECIP_RISE);
      end else begin
         fprod = 40'(span) * 40'(11'(PM_FULL - duty_cur)) *
            40'(RECIP_FALL);
      end
      freq_cur = 16'(flo_r + fprod[31:16]);
      psum = 33'(phase_r) + 33'(inc_r);
      phase_nxt = psum[31:0];
      thr_nxt = thr_r;
      inc_nxt = inc_r;
      if (mode != MODE_PROP) begin
         phase_nxt = 32'h0;
         thr_nxt = 32'h0;
         inc_nxt = 32'(freq_cur) * 32'(INC_PER_HZ);
      end else if (psum[32] || inc_r == 32'h0) begin
         // New values only at a period boundary, so no runt pulses
         thr_nxt = 32'(duty_cur) * THR_PER_PM;
         inc_nxt = 32'(freq_cur) * 32'(INC_PER_HZ);
      end
      pwm_nxt = mode == MODE_PROP && phase_nxt < thr_nxt;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         phase_r <= 32'h0;
         thr_r <= 32'h0;
         inc_r <= 32'h0;
         pwm_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         thr_r <= thr_nxt;
         inc_r <= inc_nxt;
         pwm_r <= pwm_nxt;
      end
   end

   assign PWM_OUT = pwm_r;

   // ==========================================================
   // Millisecond and control-cycle timer
   logic [31:0] ms_cnt_r, ms_cnt_nxt;
   logic [13:0] cyc_cnt_r, cyc_cnt_nxt;
   logic ms_tick, cycle_start;

   always_comb begin
      ms_tick = ms_cnt_r >= 32'(MS_CLKS - 1);
      ms_cnt_nxt = ms_tick ? 32'h0 : 32'(ms_cnt_r + 32'h1);
      cycle_start = ms_tick && cyc_cnt_r >= 14'(cycle_r - 14'h0001);
      cyc_cnt_nxt = cyc_cnt_r;
      if (cycle_start) begin
         cyc_cnt_nxt = 14'h0000;
      end else if (ms_tick) begin
         cyc_cnt_nxt = 14'(cyc_cnt_r + 14'h0001);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ms_cnt_r <= 32'h0;
         cyc_cnt_r <= 14'h0000;
      end else begin
         ms_cnt_r <= ms_cnt_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
      end
   end

   // ==========================================================
   // Time-proportional channels and output polarity
   tp_if tp1 (.clk(CLK), .rst_n(RST_N));
   tp_if tp2 (.clk(CLK), .rst_n(RST_N));
   logic timed1, timed2;
   logic v1_r, v1_nxt, v2_r, v2_nxt;

   assign timed1 = mode == MODE_PROCESS || mode == MODE_TWO ||
      mode == MODE_THREE;
   assign timed2 = mode == MODE_PROCESS || mode == MODE_THREE;
   assign tp1.ms_tick = ms_tick;
   assign tp2.ms_tick = ms_tick;
   assign tp1.cycle_start = cycle_start;
   assign tp2.cycle_start = cycle_start;
   assign tp1.cycle_ms = cycle_r;
   assign tp2.cycle_ms = cycle_r;
   assign tp1.tmin_ms = tmin1_r;
   assign tp2.tmin_ms = tmin2_r;
   // Positive variable opens on output one, negative closes on two
   assign tp1.mag_pm = (timed1 && mv_r > 11'sd0) ?
      mv_r[10:0] : 11'h000;
   assign tp2.mag_pm = (timed2 && mv_r < 11'sd0) ?
      11'(-mv_r) : 11'h000;

   tp_channel u_ch1 (.tp(tp1));
   tp_channel u_ch2 (.tp(tp2));

   // Mode change mid-cycle stops drive at once
   assign act1 = tp1.pulse && timed1;
   assign act2 = tp2.pulse && timed2 && !act1;

   always_comb begin
      v1_nxt = act1 ^ pol1;
      v2_nxt = act2 ^ pol2;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         v1_r <= 1'b0;
         v2_r <= 1'b0;
      end else begin
         v1_r <= v1_nxt;
         v2_r <= v2_nxt;
      end
   end

   assign VALVE1_OUT = v1_r;
   assign VALVE2_OUT = v2_r;

   // ==========================================================
   // Standard-signal analog output
   logic [10:0] apos;

   always_comb begin
      apos = (mv_r > 11'sd0) ? mv_r[10:0] : 11'h000;
      aout_nxt = 16'h0000;
      if (mode == MODE_STD) begin
         if (ctrl_r[CTRL_VOLT_BIT]) begin
            aout_nxt = 16'(apos * AOUT_V_STEP);
         end else begin
            aout_nxt = 16'(AOUT_MA_BASE + 16'(apos * AOUT_MA_STEP));
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         aout_r <= 16'h0000;
      end else begin
         aout_r <= aout_nxt;
      end
   end

   assign AOUT_CODE = aout_r;
   assign AOUT_VOLT = ctrl_r[CTRL_VOLT_BIT];

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   a_pwm_prop_only: assert property (PWM_OUT |->
      $past(mode) == MODE_PROP)
      else $error("pwm outside proportional mode");
   a_freq_in_range: assert property (fhi_r >= flo_r |->
      freq_cur >= flo_r && freq_cur <= fhi_r)
      else $error("pwm frequency out of limits");
   a_freq_ends_low: assert property (mode == MODE_PROP &&
      (duty_cur == 11'h000 || duty_cur == PM_FULL) |-> freq_cur == flo_r)
      else $error("frequency not at lower limit at duty end");
   a_freq_peak_high: assert property (duty_cur == PM_PEAK &&
      span >= 16'h0200 |-> freq_cur >= 16'(fhi_r - (span >> 8)))
      else $error("frequency not at upper limit at peak duty");
   a_duty_clamped: assert property (duty_cur <= dmax_r)
      else $error("duty above clamp");
   a_valves_exclusive: assert property (!(tp1.pulse && tp2.pulse))
      else $error("open and close active together");
   a_two_state_one: assert property (mode == MODE_TWO |-> !act2)
      else $error("second output active in two-state mode");
   a_polarity_map: assert property (##1 {VALVE1_OUT, VALVE2_OUT} ==
      ($past({act1, act2}) ^ $past({pol1, pol2})))
      else $error("valve output polarity wrong");
   a_tmin_limits: assert property (tmin1_r <= TMIN_MAX &&
      tmin2_r <= TMIN_MAX)
      else $error("minimum control time out of range");
   a_tmin2_write: assert property (addr_r == ADDR_TMIN2 &&
      wr_pend_r && HWDATA <= 32'(TMIN_MAX) |=> tmin2_r == $past(HWDATA[13:0]))
      else $error("second minimum time not stored");
   a_aout_ma: assert property (mode == MODE_STD &&
      !ctrl_r[CTRL_VOLT_BIT] && $stable(mv_r) && $stable(ctrl_r) |=>
      AOUT_CODE >= AOUT_MA_BASE)
      else $error("current code below 4 mA");
   a_zero_idle: assert property (timed1 && mv_r == 11'sd0 &&
      cycle_start |-> ##2 !act1 && !act2)
      else $error("valve active with zero variable");

   c_pwm_pulse: cover property (mode == MODE_PROP && $rose(PWM_OUT));
   c_open_pulse: cover property (mode == MODE_PROCESS && $rose(act1));
   c_close_pulse: cover property (mode == MODE_THREE && $rose(act2));
   c_aout_volt: cover property (mode == MODE_STD && AOUT_VOLT &&
      AOUT_CODE != 16'h0000);
endmodule

// *** vad_pkg.sv ***
// Constants, types and helper arithmetic for the valve actuator drive.
// Assumes a 100 MHz system clock and word-wide AHB-Lite register access.
package vad_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MV = 8'h04;
   localparam logic [7:0] ADDR_FREQ = 8'h08;
   localparam logic [7:0] ADDR_DMAX = 8'h0c;
   localparam logic [7:0] ADDR_TMIN1 = 8'h10;
   localparam logic [7:0] ADDR_TMIN2 = 8'h14;
   localparam logic [7:0] ADDR_CYCLE = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_AOUT = 8'h20;
   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_POL1_BIT = 3;
   localparam int CTRL_POL2_BIT = 4;
   localparam int CTRL_VOLT_BIT = 5;
   localparam int STAT_PWM_BIT = 16;
   localparam int STAT_ACT1_BIT = 17;
   localparam int STAT_ACT2_BIT = 18;
   localparam int STAT_CLAMP_BIT = 19;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [15:0] FHI_RESET = 16'h01f4;
   localparam logic [15:0] FLO_RESET = 16'h0064;
   localparam logic [10:0] DMAX_RESET = 11'h3e8;
   localparam logic [13:0] TMIN_RESET = 14'h0005;
   localparam logic [13:0] TMIN_MAX = 14'h270f;
   localparam logic [13:0] CYCLE_RESET = 14'h03e8;
   // ==========================================================
   // Duty in per mille, frequency interpolation and analog output constants
   localparam logic [10:0] PM_FULL = 11'h3e8;
   localparam logic [10:0] PM_PEAK = 11'h258;
   localparam logic [7:0] RECIP_RISE = 8'h6d;
   localparam logic [7:0] RECIP_FALL = 8'ha4;
   localparam logic [10:0] RECIP_PM = 11'h419;
   localparam logic [31:0] THR_PER_PM = 32'h00418937;
   localparam logic [5:0] INC_PER_HZ = 6'h2b;
   localparam logic [15:0] AOUT_MA_BASE = 16'h0fa0;
   localparam logic [4:0] AOUT_MA_STEP = 5'h10;
   localparam logic [3:0] AOUT_V_STEP = 4'ha;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_TIME_NS = 1000000;
   localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      MODE_OFF, MODE_PROP, MODE_PROCESS, MODE_TWO, MODE_THREE, MODE_STD
   } drive_mode_t;

   // x * pm / 1000, never above x
   function automatic logic [13:0] scale_pm(input logic [13:0] x,
                                            input logic [10:0] pm);
      logic [39:0] p;
      p = 40'(x) * 40'(pm) * 40'(RECIP_PM);
      scale_pm = (p[39:20] > 20'(x)) ? x : p[33:20];
   endfunction

   function automatic logic [13:0] clamp_tmin(input logic [31:0] w);
      clamp_tmin = (w > 32'(TMIN_MAX)) ? TMIN_MAX : w[13:0];
   endfunction
endpackage

// *** tp_if.sv ***
// Carrier between the drive core and one time-proportional channel.
// Assumes both sides share one clock and synchronous reset.
`timescale 1ns/100ps
interface tp_if (
   input wire logic clk,   // System clock
   input wire logic rst_n  // Synchronous reset, active low
);
   logic ms_tick;
   logic cycle_start;
   logic [13:0] cycle_ms;
   logic [13:0] tmin_ms;
   logic [10:0] mag_pm;
   logic pulse;
   modport core (output ms_tick, cycle_start, cycle_ms, tmin_ms, mag_pm,
      input pulse);
   modport unit (input clk, rst_n, ms_tick, cycle_start, cycle_ms, tmin_ms,
      mag_pm, output pulse);
endinterface

// *** tp_channel.sv ***
// One time-proportional pulse channel: pulse length per control cycle.
// Assumes cycle_start and ms_tick come from the core's millisecond timer.
`timescale 1ns/100ps
module tp_channel
   import vad_pkg::*;
(
   tp_if.unit tp  // Timing in, pulse out
);
   logic [13:0] on_ms_r, on_ms_nxt;
   logic [13:0] elapsed_r, elapsed_nxt;
   logic pulse_r, pulse_nxt;

   // ==========================================================
   // Pulse length latched at each cycle start
   always_comb begin
      on_ms_nxt = on_ms_r;
      if (tp.cycle_start) begin
         if (tp.mag_pm == 11'h000) begin
            on_ms_nxt = 14'h0000;
         end else if (tp.cycle_ms > tp.tmin_ms) begin
            on_ms_nxt = 14'(tp.tmin_ms +
               scale_pm(14'(tp.cycle_ms - tp.tmin_ms), tp.mag_pm));
         end else begin
            on_ms_nxt = tp.tmin_ms;
         end
      end
      elapsed_nxt = elapsed_r;
      if (tp.cycle_start) begin
         elapsed_nxt = 14'h0000;
      end else if (tp.ms_tick && elapsed_r != 14'h3fff) begin
         elapsed_nxt = 14'(elapsed_r + 14'h0001);
      end
      pulse_nxt = elapsed_nxt < on_ms_nxt;
   end

   always_ff @(posedge tp.clk) begin
      if (!tp.rst_n) begin
         on_ms_r <= 14'h0000;
         elapsed_r <= 14'h0000;
         pulse_r <= 1'b0;
      end else begin
         on_ms_r <= on_ms_nxt;
         elapsed_r <= elapsed_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign tp.pulse = pulse_r;

   // ==========================================================
   // Checks
   a_min_pulse_len: assert property (@(posedge tp.clk)
      disable iff (!tp.rst_n) tp.cycle_start && tp.mag_pm != 11'h000 |=>
      on_ms_r >= $past(tp.tmin_ms) && pulse_r == (on_ms_r != 14'h0000))
      else $error("pulse shorter than minimum control time");
   a_zero_no_pulse: assert property (@(posedge tp.clk)
      disable iff (!tp.rst_n) tp.cycle_start && tp.mag_pm == 11'h000 |=>
      !pulse_r)
      else $error("pulse with zero magnitude");
   c_pulse_seen: cover property (@(posedge tp.clk) disable iff (!tp.rst_n)
      $rose(pulse_r));
endmodule

// *** process_valve_model.sv ***
// Behavioural process valve worked by an aeration and a vent valve.
// Assumes the valve outputs of the drive feed the two coils directly.
`timescale 1ns/100ps
module process_valve_model (
   input wire logic CLK,         // System clock
   input wire logic RST_N,       // Synchronous reset, active low
   input wire logic aer_drive,   // Coil of the aeration valve
   input wire logic deaer_drive, // Coil of the vent valve
   output int pos                // Travel of the process valve
);
   logic aer_open;
   logic vent_open;
   // ==========================================================
   // Normally closed aeration, normally open vent: closes on power loss
   assign aer_open = aer_drive;
   assign vent_open = !deaer_drive;
   always @(posedge CLK) begin
      if (!RST_N)
         pos <= 0;
      else if (aer_open && !vent_open)
         pos <= pos + 1;
      else if (vent_open && !aer_open && pos > 0)
         pos <= pos - 1;
   end
endmodule

// *** valve_actuator_drive_tb.sv ***
// Self-checking bench for the valve actuator drive over AHB-Lite.
// Assumes a zero-wait slave and a shortened millisecond of 10 clocks.
`timescale 1ns/100ps
module valve_actuator_drive_tb
   import vad_pkg::*;
;
   localparam int MSC = 10;
   logic CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP;
   logic PWM_OUT, VALVE1_OUT, VALVE2_OUT, AOUT_VOLT;
   logic [31:0] HADDR, HWDATA, HRDATA, rd;
   logic [1:0] HTRANS;
   logic [15:0] AOUT_CODE;
   int n_mismatch = 0, checks = 0, cyc = 0, pos, hi, per, e;
   logic [7:0] ra [8] = '{ADDR_CTRL, ADDR_MV, ADDR_FREQ, ADDR_DMAX,
      ADDR_TMIN1, ADDR_TMIN2, ADDR_CYCLE, 8'h40};
   logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h006401f4, 32'h3e8, 32'h5,
      32'h5, 32'h3e8, 32'h0};
   int dv [3] = '{300, 600, 900};

   valve_actuator_drive #(.MS_CLKS(MSC)) uut (.CLK(CLK), .RST_N(RST_N),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PWM_OUT(PWM_OUT),
      .VALVE1_OUT(VALVE1_OUT), .VALVE2_OUT(VALVE2_OUT),
      .AOUT_CODE(AOUT_CODE), .AOUT_VOLT(AOUT_VOLT));
   process_valve_model pv (.CLK(CLK), .RST_N(RST_N),
      .aer_drive(VALVE1_OUT), .deaer_drive(VALVE2_OUT), .pos(pos));

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         give_verdict;
      end
   end
   // ==========================================================
   // Bus, measurement and compare tasks
   task give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task near(input int g, input int x, input int tol);
      checks++;
      if (g > x + tol || g < x - tol) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {24'h0, a};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask
   task chk(input logic [7:0] a, input logic [31:0] x);
      ahb(1'b0, a, 32'h0);
      cmp(rd, x);
   endtask
   task pw(input logic sel, input logic idle, output int n);
      int t;
      t = 0;
      n = 0;
      while ((sel ? VALVE2_OUT : VALVE1_OUT) === idle && t < 15000) begin
         @(negedge CLK);
         t++;
      end
      while ((sel ? VALVE2_OUT : VALVE1_OUT) !== idle && n < 15000) begin
         @(negedge CLK);
         n++;
      end
   endtask
   task vt(input logic [31:0] c, input logic [31:0] mv, input logic sel,
      input logic idle, input int ms);
      int n;
      ahb(1'b1, ADDR_CTRL, c);
      ahb(1'b1, ADDR_MV, mv);
      pw(sel, idle, n);
      pw(sel, idle, n);
      near(n, ms * MSC, MSC + 2);
      $display("valve pulse test done");
   endtask
   task pm;
      int t;
      t = 0;
      hi = 0;
      per = 0;
      repeat (2) begin
         while (PWM_OUT !== 1'b0 && t < 12000) begin
            @(negedge CLK);
            t++;
         end
         while (PWM_OUT !== 1'b1 && t < 12000) begin
            @(negedge CLK);
            t++;
         end
      end
      while (PWM_OUT === 1'b1 && per < 9000) begin
         @(negedge CLK);
         hi++;
         per++;
      end
      while (PWM_OUT !== 1'b1 && per < 9000) begin
         @(negedge CLK);
         per++;
      end
      per = (per > 0) ? per : 1;
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      RST_N = 1'b0;
      HSEL = 1'b0;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HADDR = 32'h0;
      HWDATA = 32'h0;
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      for (int i = 0; i < 8; i++)
         chk(ra[i], rv[i]);
      ahb(1'b1, ADDR_TMIN1, 32'h2710);
      chk(ADDR_TMIN1, 32'h270f);
      ahb(1'b1, ADDR_TMIN2, 32'h270f);
      chk(ADDR_TMIN2, 32'h270f);
      cmp(32'(HRESP), 32'h0);
      $display("register test done");
      ahb(1'b1, ADDR_CYCLE, 32'h14);
      ahb(1'b1, ADDR_TMIN1, 32'h5);
      ahb(1'b1, ADDR_TMIN2, 32'ha);
      vt(32'(MODE_TWO), 32'h190, 1'b0, 1'b0, 11);
      vt(32'(MODE_TWO) | 32'h8, 32'h190, 1'b0, 1'b1, 11);
      vt(32'(MODE_THREE), 32'hfffffe70, 1'b1,
         1'b0, 14);
      ahb(1'b1, ADDR_MV, 32'h0);
      repeat (250) @(negedge CLK);
      hi = 0;
      repeat (250) @(negedge CLK) hi += (VALVE1_OUT | VALVE2_OUT);
      near(hi, 0, 0);
      vt(32'(MODE_PROCESS) | 32'h10, 32'h190, 1'b0, 1'b0, 11);
      cmp(32'(VALVE2_OUT), 32'h1);
      cmp(32'(pos > 0), 32'h1);
      hi = pos;
      vt(32'(MODE_PROCESS) | 32'h10, 32'hfffffe70, 1'b1, 1'b1, 14);
      cmp(32'(pos < hi), 32'h1);
      ahb(1'b1, ADDR_TMIN1, 32'h0);
      vt(32'(MODE_TWO), 32'h190, 1'b0, 1'b0, 8);
      ahb(1'b1, ADDR_FREQ, 32'h4e20c350);
      ahb(1'b1, ADDR_CTRL, 32'(MODE_PROP));
      for (int i = 0; i < 3; i++) begin
         ahb(1'b1, ADDR_MV, 32'(dv[i]));
         pm;
         e = dv[i] <= 600 ? 20000 + 50 * dv[i] : 20000 + 75 * (1000 - dv[i]);
         e = int'(64'h100000000 / (64'(e) * 43));
         near(per, e, e / 40);
         near(hi * 1000 / per, dv[i], 10);
      end
      ahb(1'b1, ADDR_DMAX, 32'h1f4);
      ahb(1'b1, ADDR_MV, 32'h320);
      pm;
      near(hi * 1000 / per, 500, 10);
      ahb(1'b0, ADDR_STATUS, 32'h0);
      cmp(32'(rd[STAT_CLAMP_BIT]), 32'h1);
      near(int'(rd[15:0]), 45000, 100);
      $display("pwm test done");
      for (int i = 0; i < 4; i++) begin
         ahb(1'b1, ADDR_CTRL, 32'(MODE_STD) | (i[1] ? 32'h20 : 32'h0));
         ahb(1'b1, ADDR_MV, i[0] ? 32'h1f4 : 32'h0);
         repeat (4) @(negedge CLK);
         e = i[1] ? 5000 * i[0] : 4000 + 8000 * i[0];
         cmp(32'(AOUT_CODE), 32'(e));
         cmp(32'(AOUT_VOLT), 32'(i[1]));
      end
      $display("analog test done");
      give_verdict;
   end
endmodule
